// ===== tb/ral_host_model.sv
// Host processor model issuing indexed register accesses
`timescale 1ns/10ps
`default_nettype none
module ral_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       oe_n_in,
    output logic            addr_wr_out,
    output logic            data_wr_out,
    output logic            data_rd_out,
    output logic [7:0]      wdata_out
);
    initial begin
        addr_wr_out = 1'b0;
        data_wr_out = 1'b0;
        data_rd_out = 1'b0;
        wdata_out   = 8'hA5;
    end

    // One strobe, data set up early and then released as inverse
    task automatic strobe(input logic sel, input logic [7:0] v);
        @(posedge clk_in);
        wdata_out <= v;
        repeat (2) @(posedge clk_in);
        if (sel) addr_wr_out <= 1'b1;
        else data_wr_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        addr_wr_out <= 1'b0;
        data_wr_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        wdata_out <= ~v;
        repeat (2) @(posedge clk_in);
    endtask

    // Index first, then data port
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        strobe(1'b1, idx);
        strobe(1'b0, v);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] v, output logic ok);
        integer n;
        strobe(1'b1, idx);
        ok = 1'b0;
        v  = 8'h00;
        data_rd_out <= 1'b1;
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge clk_in);
            #1;
            if (oe_n_in === 1'b0) begin
                ok = 1'b1;
                v  = rdata_in;
            end
        end
        @(posedge clk_in);
        data_rd_out <= 1'b0;
        for (n = 0; n < 12 && oe_n_in !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        repeat (3) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ===== tb/ral_top_tb.sv
// Self-checking bench for the alarm latch and interrupt block
`timescale 1ns/10ps
`default_nettype none
module ral_top_tb;
    logic            clk_in;
    logic            rst_n_in;
    logic            addr_wr;
    logic            data_wr;
    logic            data_rd;
    logic [7:0]      wdata;
    logic [7:0]      rdata;
    logic            oe_n;
    logic            irq;
    logic [7:0][7:0] cnt;
    logic [7:1]      roll;
    int              miscompares;
    int              checked;
    int              i;

    ral_top DUT (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .addr_wr_in    (addr_wr),
        .data_wr_in    (data_wr),
        .data_rd_in    (data_rd),
        .data_in       (wdata),
        .count_in      (cnt),
        .rollover_in   (roll),
        .data_out      (rdata),
        .data_oe_n_out (oe_n),
        .irq_out       (irq)
    );

    ral_host_model host (
        .clk_in      (clk_in),
        .rdata_in    (rdata),
        .oe_n_in     (oe_n),
        .addr_wr_out (addr_wr),
        .data_wr_out (data_wr),
        .data_rd_out (data_rd),
        .wdata_out   (wdata)
    );

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        logic       ok;
        host.rd(idx, v, ok);
        chk({name, " answer"}, 8'h01, {7'h00, ok});
        chk(name, exp, v);
    endtask

    task automatic pulse(input int n);
        logic [7:0] m;
        m = 8'h01 << n;
        @(posedge clk_in);
        roll <= m[7:1];
        @(posedge clk_in);
        roll <= 7'h00;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    function automatic logic [7:0] lat(input int k);
        return (k == 2) ? ral_pkg::DONT_CARE : 8'h10 * k[7:0] + 8'h05;
    endfunction

    initial begin
        #1000000;
        miscompares++;
        $display("[FAIL] watchdog expected done seen hang");
        end_sim();
    end

    initial begin
        miscompares = 0;
        checked     = 0;
        rst_n_in    = 1'b0;
        cnt         = '0;
        roll        = 7'h00;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk("irq after reset", 8'h00, {7'h00, irq});
        rchk("enable reset", ral_pkg::IDX_ENABLE, ral_pkg::ENABLE_RST);
        rchk("cause reset", ral_pkg::IDX_CAUSE, ral_pkg::CAUSE_RST);
        $display("test reset done");
        for (i = 0; i < 8; i++) host.wr(ral_pkg::IDX_LATCH_FIRST + i[7:0], lat(i));
        for (i = 0; i < 8; i++) begin
            rchk("latch", ral_pkg::IDX_LATCH_FIRST + i[7:0], lat(i));
        end
        rchk("hours latch", ral_pkg::IDX_HOURS_LATCH, 8'h35);
        rchk("month latch", ral_pkg::IDX_MONTH_LATCH, 8'h75);
        $display("test latches done");
        for (i = 0; i < 8; i++) cnt[i] <= lat(i);
        cnt[0] <= 8'h00;
        cnt[2] <= 8'h99;
        host.wr(ral_pkg::IDX_ENABLE, 8'h01);
        rchk("cause flush", ral_pkg::IDX_CAUSE, 8'h00);
        chk("irq before match", 8'h00, {7'h00, irq});
        @(posedge clk_in);
        cnt[0] <= 8'h05;
        repeat (4) @(posedge clk_in);
        #1;
        chk("irq on match", 8'h01, {7'h00, irq});
        repeat (12) @(posedge clk_in);
        #1;
        chk("irq held", 8'h01, {7'h00, irq});
        rchk("cause alarm", ral_pkg::IDX_CAUSE, 8'h01);
        chk("irq after read", 8'h00, {7'h00, irq});
        rchk("cause cleared", ral_pkg::IDX_CAUSE, 8'h00);
        cnt[0] <= 8'h00;
        $display("test alarm done");
        for (i = 1; i < 8; i++) begin
            host.wr(ral_pkg::IDX_ENABLE, 8'h01 << i);
            pulse((i % 7) + 1);
            chk("irq disabled source", 8'h00, {7'h00, irq});
            pulse(i);
            chk("irq rollover", 8'h01, {7'h00, irq});
            rchk("cause rollover", ral_pkg::IDX_CAUSE, 8'h01 << i);
            chk("irq rollover cleared", 8'h00, {7'h00, irq});
        end
        host.wr(ral_pkg::IDX_ENABLE, 8'h06);
        pulse(1);
        pulse(2);
        pulse(5);
        rchk("cause two sources", ral_pkg::IDX_CAUSE, 8'h06);
        rchk("enable readback", ral_pkg::IDX_ENABLE, 8'h06);
        $display("test rollover done");
        host.wr(ral_pkg::IDX_CTR_CLEAR, ral_pkg::CLEAR_ALL);
        rchk("latch after counter clear", ral_pkg::IDX_HOURS_LATCH, 8'h35);
        rchk("counter clear reads zero", ral_pkg::IDX_CTR_CLEAR, ral_pkg::READ_ZERO);
        host.wr(ral_pkg::IDX_LAST, 8'hFF);
        rchk("enable after unmapped write", ral_pkg::IDX_ENABLE, 8'h06);
        host.wr(ral_pkg::IDX_LATCH_CLEAR, ral_pkg::CLEAR_ALL);
        for (i = 0; i < 8; i++) begin
            rchk("latch zero", ral_pkg::IDX_LATCH_FIRST + i[7:0], ral_pkg::LATCH_MIN);
        end
        $display("test reset locations done");
        end_sim();
    end
endmodule
`default_nettype wire

// ===== verilog/ral_cause.sv
// Interrupt cause register and interrupt output
`timescale 1ns/10ps
`default_nettype none
module ral_cause (
    input  wire logic                          clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic [ral_pkg::NUM_SRC-1:0]   event_in,
    input  wire logic [ral_pkg::NUM_SRC-1:0]   enable_in,
    input  wire logic                          clear_in,
    output logic [ral_pkg::NUM_SRC-1:0]        cause_out,
    output logic                               irq_out
);
    logic [ral_pkg::NUM_SRC-1:0] next_cause;
    logic                        next_irq;

    // ---------------------------------------------------------------
    // Set wins over clear
    // ---------------------------------------------------------------
    always_comb begin
        next_cause = cause_out & ~{ral_pkg::NUM_SRC{clear_in}};
        next_cause = next_cause | (event_in & enable_in);
        next_irq   = |next_cause;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cause_out <= ral_pkg::CAUSE_RST;
            irq_out   <= 1'b0;
        end else begin
            cause_out <= next_cause;
            irq_out   <= next_irq;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_ENABLED_SETS: assert property (
        (event_in[0] && enable_in[0]) |=> (cause_out[0] && irq_out))
        else $error("Enabled source did not set cause and interrupt");
    AST_DISABLED_IGNORED: assert property (
        (event_in[2] && !enable_in[2] && !cause_out[2]) |=> !cause_out[2])
        else $error("Disabled source recorded a cause");
    AST_READ_CLEARS: assert property (
        (clear_in && !(|(event_in & enable_in))) |=> (cause_out == '0 && !irq_out))
        else $error("Cause read did not clear status and interrupt");
    AST_IRQ_HOLDS: assert property (
        (irq_out && !clear_in) |=> irq_out)
        else $error("Interrupt dropped without cause read");
    AST_ANY_SOURCE: assert property (
        (|(event_in & enable_in)) |=> irq_out)
        else $error("Selected source did not raise interrupt");
endmodule
`default_nettype wire

// ===== verilog/ral_match.sv
// Alarm comparator: eight latches against eight counters
`timescale 1ns/10ps
`default_nettype none
module ral_match (
    input  wire logic                                       clk_in,
    input  wire logic                                       rst_n_in,
    input  wire logic [ral_pkg::NUM_LATCH-1:0][7:0]         latch_in,
    input  wire logic [ral_pkg::NUM_LATCH-1:0][7:0]         count_in,
    output logic                                            match_pulse_out
);
    logic [ral_pkg::NUM_LATCH-1:0] lane_eq;
    logic                          match_q;
    logic                          next_match;
    logic                          next_pulse;

    // ---------------------------------------------------------------
    // Per-lane compare
    // ---------------------------------------------------------------
    for (genvar i = 0; i < ral_pkg::NUM_LATCH; i++) begin : g_lane
        assign lane_eq[i] = (latch_in[i] == ral_pkg::DONT_CARE) ||
                            (latch_in[i] == count_in[i]);
    end

    always_comb begin
        next_match = &lane_eq;
        next_pulse = next_match & ~match_q;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            match_q         <= 1'b0;
            match_pulse_out <= 1'b0;
        end else begin
            match_q         <= next_match;
            match_pulse_out <= next_pulse;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_DONT_CARE_LANE: assert property (
        (latch_in[0] == ral_pkg::DONT_CARE) |-> lane_eq[0])
        else $error("Don't-care latch not treated as equal");
    AST_MATCH_PULSE: assert property (
        (&lane_eq && !match_q) |=> match_pulse_out)
        else $error("Full match gave no alarm event");
    AST_NO_FALSE_MATCH: assert property (
        !(&lane_eq) |=> !match_pulse_out)
        else $error("Alarm event without full match");
endmodule
`default_nettype wire

// ===== verilog/ral_pkg.sv
// Constants and types shared by the alarm latch and interrupt logic
package ral_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned NUM_LATCH = 8;
    localparam int unsigned LANE_W    = 3;
    localparam int unsigned NUM_SRC   = 8;

    // ---------------------------------------------------------------
    // Indirect register indices
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_LATCH_FIRST = 8'h08;
    localparam logic [7:0] IDX_LATCH_LAST  = 8'h0F;
    localparam logic [7:0] IDX_HOURS_LATCH = 8'h0B;
    localparam logic [7:0] IDX_MONTH_LATCH = 8'h0F;
    localparam logic [7:0] IDX_CAUSE       = 8'h10;
    localparam logic [7:0] IDX_ENABLE      = 8'h11;
    localparam logic [7:0] IDX_CTR_CLEAR   = 8'h12;
    localparam logic [7:0] IDX_LATCH_CLEAR = 8'h13;
    localparam logic [7:0] IDX_LAST        = 8'h15;

    // ---------------------------------------------------------------
    // Data codes and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] DONT_CARE  = 8'hCC;
    localparam logic [7:0] CLEAR_ALL  = 8'hFF;
    localparam logic [7:0] LATCH_MIN  = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] CAUSE_RST  = 8'h00;
    localparam logic [7:0] ADDR_RST   = 8'h00;
    localparam logic [7:0] RDATA_RST  = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // ---------------------------------------------------------------
    // Cause and enable bit positions
    // ---------------------------------------------------------------
    localparam int unsigned BIT_ALARM  = 0;
    localparam int unsigned BIT_TENTH  = 1;
    localparam int unsigned BIT_SECOND = 2;
    localparam int unsigned BIT_MINUTE = 3;
    localparam int unsigned BIT_HOUR   = 4;
    localparam int unsigned BIT_DAY    = 5;
    localparam int unsigned BIT_WEEK   = 6;
    localparam int unsigned BIT_MONTH  = 7;

    // ---------------------------------------------------------------
    // Host access phase
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_READ = 2'b10
    } ral_bus_t;

endpackage

// ===== verilog/ral_top.sv
// Alarm latches, interrupt control and indexed host access
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - All eight latches equal counters sets alarm
// - Latch holding CC always compares equal
// - Hours latch at 11, month at 15
// - Latch read returns stored value, CC included
// - Latch reset at 19, counter reset 18
// - Writing all ones clears latches to minimum
// - Shared bit layout, month down to alarm
// - Enable bit one enables source, zero disables
// - Several enables give fastest selected rate
// - Cause at index 16, enable at 17
// - Cause bit one when source caused interrupt
// - Reading cause clears bits and interrupt
// - Causes recorded only for enabled sources
module ral_top (
    input  wire logic                                   clk_in,
    input  wire logic                                   rst_n_in,
    input  wire logic                                   addr_wr_in,
    input  wire logic                                   data_wr_in,
    input  wire logic                                   data_rd_in,
    input  wire logic [7:0]                             data_in,
    input  wire logic [ral_pkg::NUM_LATCH-1:0][7:0]     count_in,
    input  wire logic [ral_pkg::NUM_SRC-1:1]            rollover_in,
    output logic [7:0]                                  data_out,
    output logic                                        data_oe_n_out,
    output logic                                        irq_out
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [2:0]  strobe_prev;
    logic        aw_edge;
    logic        dw_edge;
    logic        rd_edge;
    logic        rd_level;
    logic [7:0]  wdata;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1       <= '0;
            sync2       <= '0;
            strobe_prev <= '0;
        end else begin
            sync1       <= {data_rd_in, data_wr_in, addr_wr_in, data_in};
            sync2       <= sync1;
            strobe_prev <= sync2[10:8];
        end
    end

    always_comb begin
        wdata    = sync2[7:0];
        aw_edge  = sync2[8] & ~strobe_prev[0];
        dw_edge  = sync2[9] & ~strobe_prev[1];
        rd_edge  = sync2[10] & ~strobe_prev[2];
        rd_level = sync2[10];
    end

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [7:0]                         addr_idx;
    logic [ral_pkg::NUM_LATCH-1:0][7:0] latch;
    logic [7:0]                         src_enable;
    ral_pkg::ral_bus_t                  bus_state;
    logic [7:0]                         next_addr_idx;
    logic [ral_pkg::NUM_LATCH-1:0][7:0] next_latch;
    logic [7:0]                         next_src_enable;
    ral_pkg::ral_bus_t                  next_bus_state;
    logic [7:0]                         next_data_out;
    logic                               next_data_oe_n;
    logic [7:0]                         read_mux;
    logic                               cause_clear;
    logic                               in_latch_range;
    logic [ral_pkg::LANE_W-1:0]         lane;
    logic [ral_pkg::NUM_SRC-1:0]        cause;
    logic [ral_pkg::NUM_SRC-1:0]        src_event;
    logic                               match_pulse;

    // ---------------------------------------------------------------
    // Index decode and read data
    // ---------------------------------------------------------------
    always_comb begin
        lane           = addr_idx[ral_pkg::LANE_W-1:0];
        in_latch_range = (addr_idx >= ral_pkg::IDX_LATCH_FIRST) &&
                         (addr_idx <= ral_pkg::IDX_LATCH_LAST);
        if (addr_idx < ral_pkg::IDX_LATCH_FIRST) begin
            read_mux = count_in[lane];
        end else if (in_latch_range) begin
            read_mux = latch[lane];
        end else if (addr_idx == ral_pkg::IDX_CAUSE) begin
            read_mux = cause;
        end else if (addr_idx == ral_pkg::IDX_ENABLE) begin
            read_mux = src_enable;
        end else begin
            read_mux = ral_pkg::READ_ZERO;
        end
    end

    // ---------------------------------------------------------------
    // Next values of host-visible state
    // ---------------------------------------------------------------
    always_comb begin
        next_addr_idx   = addr_idx;
        next_latch      = latch;
        next_src_enable = src_enable;
        next_bus_state  = bus_state;
        next_data_out   = data_out;
        cause_clear     = 1'b0;
        if (aw_edge) begin
            next_addr_idx = wdata;
        end
        if (dw_edge) begin
            if (in_latch_range) begin
                next_latch[lane] = wdata;
            end else if (addr_idx == ral_pkg::IDX_ENABLE) begin
                next_src_enable = wdata;
            end else if (addr_idx == ral_pkg::IDX_LATCH_CLEAR) begin
                for (int i = 0; i < ral_pkg::NUM_LATCH; i++) begin
                    if (wdata[i]) begin
                        next_latch[i] = ral_pkg::LATCH_MIN;
                    end
                end
            end
        end
        case (bus_state)
            ral_pkg::BUS_IDLE: begin
                if (rd_edge) begin
                    next_data_out  = read_mux;
                    next_bus_state = ral_pkg::BUS_READ;
                    cause_clear    = (addr_idx == ral_pkg::IDX_CAUSE);
                end
            end
            ral_pkg::BUS_READ: begin
                if (!rd_level) begin
                    next_bus_state = ral_pkg::BUS_IDLE;
                end
            end
            default: begin
                next_bus_state = ral_pkg::BUS_IDLE;
            end
        endcase
        next_data_oe_n = (next_bus_state != ral_pkg::BUS_READ);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_idx      <= ral_pkg::ADDR_RST;
            latch         <= '0;
            src_enable    <= ral_pkg::ENABLE_RST;
            bus_state     <= ral_pkg::BUS_IDLE;
            data_out      <= ral_pkg::RDATA_RST;
            data_oe_n_out <= 1'b1;
        end else begin
            addr_idx      <= next_addr_idx;
            latch         <= next_latch;
            src_enable    <= next_src_enable;
            bus_state     <= next_bus_state;
            data_out      <= next_data_out;
            data_oe_n_out <= next_data_oe_n;
        end
    end

    // ---------------------------------------------------------------
    // Alarm compare and interrupt causes
    // ---------------------------------------------------------------
    assign src_event = {rollover_in, match_pulse};

    ral_match u_match (
        .clk_in          (clk_in),
        .rst_n_in        (rst_n_in),
        .latch_in        (latch),
        .count_in        (count_in),
        .match_pulse_out (match_pulse)
    );

    ral_cause u_cause (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .event_in  (src_event),
        .enable_in (src_enable),
        .clear_in  (cause_clear),
        .cause_out (cause),
        .irq_out   (irq_out)
    );

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence seq_select_cause;
        aw_edge && (wdata == ral_pkg::IDX_CAUSE);
    endsequence

    sequence seq_read_edge;
        rd_edge && (bus_state == ral_pkg::BUS_IDLE);
    endsequence

    AST_ADDR_LATCH: assert property (
        aw_edge |=> (addr_idx == $past(wdata)))
        else $error("Index write not captured");
    AST_LATCH_WRITE: assert property (
        (dw_edge && in_latch_range) |=> (latch[$past(lane)] == $past(wdata)))
        else $error("Latch write not stored");
    AST_HOURS_MAP: assert property (
        (dw_edge && addr_idx == ral_pkg::IDX_HOURS_LATCH) |=> (latch[3] == $past(wdata)))
        else $error("Hours latch index mapped wrongly");
    AST_MONTH_MAP: assert property (
        (dw_edge && addr_idx == ral_pkg::IDX_MONTH_LATCH) |=> (latch[7] == $past(wdata)))
        else $error("Month latch index mapped wrongly");
    AST_LATCH_READ: assert property (
        (seq_read_edge and in_latch_range) |=> (data_out == latch[$past(lane)]))
        else $error("Latch read returned wrong value");
    AST_CLEAR_ALL: assert property (
        (dw_edge && addr_idx == ral_pkg::IDX_LATCH_CLEAR && wdata == ral_pkg::CLEAR_ALL)
        |=> (latch == '0))
        else $error("Latch reset did not clear all latches");
    AST_CTR_CLEAR_SEPARATE: assert property (
        (dw_edge && addr_idx == ral_pkg::IDX_CTR_CLEAR) |=> (latch == $past(latch)))
        else $error("Counter reset disturbed latches");
    AST_ENABLE_WRITE: assert property (
        (dw_edge && addr_idx == ral_pkg::IDX_ENABLE) |=> (src_enable == $past(wdata)))
        else $error("Enable register write lost");
    AST_CAUSE_READ: assert property (
        (seq_read_edge ##0 (addr_idx == ral_pkg::IDX_CAUSE))
        |=> (data_out == $past(cause)) ##0 (data_oe_n_out == 1'b0))
        else $error("Cause read returned wrong value");
    AST_OE_RELEASE: assert property (
        (bus_state == ral_pkg::BUS_READ && !rd_level) |=> ##1 data_oe_n_out)
        else $error("Data bus not released after read");

    // ---------------------------------------------------------------
    // Read path checks
    // ---------------------------------------------------------------
    sequence seq_read_latch;
        seq_read_edge ##0 in_latch_range;
    endsequence

    sequence seq_read_cause;
        seq_read_edge ##0 (addr_idx == ral_pkg::IDX_CAUSE);
    endsequence

    AST_CAUSE_SELECT: assert property (
        seq_select_cause |=> (addr_idx == ral_pkg::IDX_CAUSE))
        else $error("Cause index not selected");
    AST_DONT_CARE_READ: assert property (
        (seq_read_latch ##0 (latch[lane] == ral_pkg::DONT_CARE))
        |=> (data_out == ral_pkg::DONT_CARE))
        else $error("Don't-care latch read back wrongly");
    AST_ENABLE_READ: assert property (
        (seq_read_edge ##0 (addr_idx == ral_pkg::IDX_ENABLE))
        |=> (data_out == $past(src_enable)))
        else $error("Enable read returned wrong value");
    AST_UNMAPPED_READ: assert property (
        (seq_read_edge ##0 (addr_idx > ral_pkg::IDX_ENABLE))
        |=> (data_out == ral_pkg::READ_ZERO))
        else $error("Unmapped index did not read zero");
    AST_OE_DRIVE: assert property (
        seq_read_edge |=> !data_oe_n_out)
        else $error("Data bus not driven on read");
    AST_READ_HOLD: assert property (
        (bus_state == ral_pkg::BUS_READ) |=> $stable(data_out))
        else $error("Read data changed during read phase");
    AST_IRQ_AFTER_READ: assert property (
        (seq_read_cause ##0 !(|(src_event & src_enable))) |=> !irq_out)
        else $error("Interrupt not released by cause read");

    // ---------------------------------------------------------------
    // Write path checks
    // ---------------------------------------------------------------
    AST_LAST_INDEX_REFUSED: assert property (
        (dw_edge && addr_idx == ral_pkg::IDX_LAST)
        |=> ((latch == $past(latch)) && (src_enable == $past(src_enable))))
        else $error("Write to unmapped index changed state");
    for (genvar k = 0; k < ral_pkg::NUM_LATCH; k++) begin : g_clear_chk
        AST_CLEAR_LANE: assert property (
            @(posedge clk_in) disable iff (!rst_n_in)
            (dw_edge && addr_idx == ral_pkg::IDX_LATCH_CLEAR && wdata[k])
            |=> (latch[k] == ral_pkg::LATCH_MIN))
            else $error("Latch reset missed a latch");
    end

    // ---------------------------------------------------------------
    // Cause layout checks
    // ---------------------------------------------------------------
    AST_ALARM_BIT: assert property (
        (match_pulse && src_enable[ral_pkg::BIT_ALARM]) |=> cause[ral_pkg::BIT_ALARM])
        else $error("Alarm event not recorded in bit 0");
    AST_MONTH_BIT: assert property (
        (rollover_in[ral_pkg::BIT_MONTH] && src_enable[ral_pkg::BIT_MONTH])
        |=> cause[ral_pkg::BIT_MONTH])
        else $error("Month rollover not recorded in bit 7");
    AST_DISABLED_SOURCE: assert property (
        (rollover_in[ral_pkg::BIT_SECOND] && !src_enable[ral_pkg::BIT_SECOND]
         && !cause[ral_pkg::BIT_SECOND]) |=> !cause[ral_pkg::BIT_SECOND])
        else $error("Disabled second rollover recorded");
    AST_FASTEST_RATE: assert property (
        (rollover_in[ral_pkg::BIT_TENTH] && src_enable[ral_pkg::BIT_TENTH]
         && src_enable[ral_pkg::BIT_SECOND]) |=> irq_out)
        else $error("Fastest selected source did not interrupt");
endmodule
`default_nettype wire
